/* dv/mbs_ctl.sv */
`timescale 1ns/1ps
module mbs_ctl (
    // test port
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    initial {tck, tms, tdi} = 3'h0;
    task automatic step(input logic m, d, output logic o);
        @(posedge clk) #1 {tms, tdi} = {m, d};
        #100 {o, tck} = {tdo, 1'h1};
        #100 tck = 1'h0;
    endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    // ========================================
    // expected identity fields, arbitrary values
    localparam logic [3:0]  REV_EXP = 4'hA;
    localparam logic [15:0] DEV_EXP = 16'h5C3E;
    localparam logic [10:0] MFR_EXP = 11'h2B7;
    localparam int          LIMIT   = 60000;

    logic         clk   = 1'h0;
    logic         rst_n = 1'h0;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdo_oe;
    logic [112:0] ring_in = '0;
    logic [112:0] ring_test_out;
    logic         test_drive;
    logic         force_hiz;
    logic [7:0]   active_ir;
    logic [127:0] shin;
    logic [127:0] shout;
    logic [7:0]   byp_codes [4];
    int           num_errors = 0;
    int           checks     = 0;
    int           seed       = 37;
    int           cycles     = 0;

    always #12.5 clk = ~clk;

    mbs_ctl u_ctl (
        .clk (clk),
        .tdo (tdo),
        .tck (tck),
        .tms (tms),
        .tdi (tdi)
    );

    mbs_tap #(
        .REV_ID (REV_EXP),
        .DEV_ID (DEV_EXP),
        .MFR_ID (MFR_EXP)
    ) dut (
        .clk           (clk),
        .rst_n         (rst_n),
        .tck           (tck),
        .tms           (tms),
        .tdi           (tdi),
        .tdo           (tdo),
        .tdo_oe        (tdo_oe),
        .ring_in       (ring_in),
        .ring_test_out (ring_test_out),
        .test_drive    (test_drive),
        .force_hiz     (force_hiz),
        .active_ir     (active_ir)
    );

    // ========================================
    // checking and verdict
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t %h %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a run that outlives the limit counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    // ========================================
    // model of a data path of len cells: captured bits leave first, then the input
    task automatic model_dr(input int len, input logic [127:0] cap, input int n,
                            output logic [127:0] exp);
        bit q[$];
        exp = '0;
        for (int i = 0; i < len; i++) begin
            q.push_back(cap[i]);
        end
        for (int i = 0; i < n; i++) begin
            q.push_back(shin[i]);
            exp[i] = q.pop_front();
        end
    endtask

    // ========================================
    // controller sequences, all starting from idle or test-logic-reset
    task automatic shift_ir(input logic [7:0] code, output logic [7:0] cap);
        logic o;
        u_ctl.step(1'h0, 1'h0, o);
        u_ctl.step(1'h1, 1'h0, o);
        u_ctl.step(1'h1, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
        for (int i = 0; i < 8; i++) begin
            u_ctl.step(i == 7, code[i], o);
            cap[i] = o;
        end
        u_ctl.step(1'h1, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
    endtask

    task automatic shift_dr(input int n);
        logic o;
        u_ctl.step(1'h0, 1'h0, o);
        u_ctl.step(1'h1, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
        shout = '0;
        for (int i = 0; i < n; i++) begin
            u_ctl.step(i == n - 1, shin[i], o);
            shout[i] = o;
        end
        u_ctl.step(1'h1, 1'h0, o);
        u_ctl.step(1'h0, 1'h0, o);
    endtask

    task automatic new_shin;
        shin = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endtask

    // ========================================
    // scenarios
    initial begin
        logic [7:0]   cap;
        logic [127:0] exp;
        logic         o;
        byp_codes = '{mbs_pkg::OP_BYPASS, mbs_pkg::OP_CLAMP, mbs_pkg::OP_HIGHZ, 8'h5A};
        repeat (20) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (2) @(posedge clk);
        #1 chk(active_ir, mbs_pkg::OP_IDCODE);
        new_shin();
        shift_dr(32);
        model_dr(32, {96'h0, REV_EXP, DEV_EXP, MFR_EXP, 1'h1}, 32, exp);
        chk(shout[31:0], exp[31:0]);
        chk(tdo_oe, 1'h0);
        foreach (byp_codes[k]) begin
            shift_ir(byp_codes[k], cap);
            chk(cap[1:0], mbs_pkg::IR_CAPTURE);
            chk(active_ir, byp_codes[k]);
            new_shin();
            shift_dr(20);
            model_dr(1, 128'h0, 20, exp);
            chk(shout[19:0], exp[19:0]);
            chk(test_drive, byp_codes[k] == mbs_pkg::OP_CLAMP);
            chk(force_hiz, byp_codes[k] == mbs_pkg::OP_HIGHZ);
        end
        ring_in = 113'({$random(seed), $random(seed), $random(seed), $random(seed)});
        shift_ir(mbs_pkg::OP_SAMPLE, cap);
        chk(test_drive, 1'h0);
        new_shin();
        shift_dr(113);
        model_dr(113, 128'(ring_in), 113, exp);
        chk(128'(shout[112:0]), 128'(exp[112:0]));
        chk(ring_test_out, shin[112:0]);
        ring_in = 113'({$random(seed), $random(seed), $random(seed), $random(seed)});
        shift_ir(mbs_pkg::OP_EXTEST, cap);
        chk(test_drive, 1'h1);
        chk(force_hiz, 1'h0);
        chk(ring_test_out, shin[112:0]);
        new_shin();
        shift_dr(113);
        model_dr(113, 128'(ring_in), 113, exp);
        chk(128'(shout[112:0]), 128'(exp[112:0]));
        chk(ring_test_out, shin[112:0]);
        repeat (5) u_ctl.step(1'h1, 1'h0, o);
        chk(active_ir, mbs_pkg::OP_IDCODE);
        chk(test_drive, 1'h0);
        shift_ir(mbs_pkg::OP_BYPASS, cap);
        chk(active_ir, mbs_pkg::OP_BYPASS);
        @(posedge clk);
        #1 rst_n = 1'h0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (2) @(posedge clk);
        #1 chk(active_ir, mbs_pkg::OP_IDCODE);
        new_shin();
        shift_dr(32);
        model_dr(32, {96'h0, REV_EXP, DEV_EXP, MFR_EXP, 1'h1}, 32, exp);
        chk(shout[31:0], exp[31:0]);
        complete_run();
    end
endmodule

/* verilog/mbs_pkg.sv */
package mbs_pkg;
    // ========================================
    // scan path sizes
    localparam int IR_W   = 8;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 113;

    // ========================================
    // instruction codes
    localparam logic [7:0] OP_EXTEST  = 8'h00;
    localparam logic [7:0] OP_IDCODE  = 8'h21;
    localparam logic [7:0] OP_SAMPLE  = 8'h05;
    localparam logic [7:0] OP_CLAMP   = 8'h07;
    localparam logic [7:0] OP_HIGHZ   = 8'h03;
    localparam logic [7:0] OP_BYPASS  = 8'hFF;

    // ========================================
    // capture pattern and id field layout
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam int ID_REV_LSB = 28;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_MFR_LSB = 1;

    // ========================================
    // reset values
    localparam logic [7:0] IR_RESET   = OP_IDCODE;

    typedef enum logic [3:0] {
        MBS_RESET, MBS_IDLE, MBS_SEL_DR, MBS_CAP_DR, MBS_SH_DR, MBS_EX1_DR,
        MBS_PAU_DR, MBS_EX2_DR, MBS_UPD_DR, MBS_SEL_IR, MBS_CAP_IR, MBS_SH_IR,
        MBS_EX1_IR, MBS_PAU_IR, MBS_EX2_IR, MBS_UPD_IR
    } mbs_state_t;
endpackage

/* verilog/mbs_sync.sv */
`timescale 1ns/1ps
module mbs_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            q    <= s1_r;
        end
    end
endmodule

/* verilog/mbs_tap.sv */
`timescale 1ns/1ps
// Contract
// R1: scan paths are 8-bit instruction, 1-bit bypass, 32-bit id, 113-bit boundary.
// R2: extest and sample/preload capture the ring and shift the boundary register.
// R3: idcode instruction captures the id value and shifts the id register.
// R4: clamp shifts bypass while outputs drive the boundary register's held values.
// R5: high-z instruction shifts bypass and forces every output to high impedance.
// R6: all-ones code shifts bypass, memory operation untouched.
// R7: id holds revision 31:28, device 27:12, manufacturer 11:1.
// R8: id bit 0 always reads one.
// R9: boundary chain has 113 cells, bit 1 exits first toward serial out.
// R10: tap states and capture/shift/update sequencing follow the standard controller.
// R11: idcode is the active instruction at reset and in test-logic-reset.
// R12: capture-ir loads the two low instruction bits with 01.
// R13: bypass register is cleared when the bypass instruction captures.
// R14: reserved codes put the bypass register in the serial path.
module mbs_tap #(
    parameter logic [3:0]  REV_ID = 4'h1,    // arbitrary value
    parameter logic [15:0] DEV_ID = 16'h1234, // arbitrary value
    parameter logic [10:0] MFR_ID = 11'h155   // arbitrary value
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // test port pins
    input  wire logic                   tck,
    input  wire logic                   tms,
    input  wire logic                   tdi,
    output logic                        tdo,
    output logic                        tdo_oe,
    // io ring
    input  wire logic [mbs_pkg::BSR_W-1:0] ring_in,
    output logic      [mbs_pkg::BSR_W-1:0] ring_test_out,
    output logic                        test_drive,
    output logic                        force_hiz,
    output logic      [7:0]             active_ir
);
    // ========================================
    // pin synchronisers and test clock edges
    logic [2:0]                pin_s;
    logic [mbs_pkg::BSR_W-1:0] ring_s;
    logic                      tck_s;
    logic                      tms_s;
    logic                      tdi_s;
    logic                      tck_d_r;
    logic                      rise;
    logic                      fall;

    mbs_sync #(
        .W     (3)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({tck, tms, tdi}),
        .q     (pin_s)
    );

    // ring inputs belong to the memory's own clock, so they are resampled too
    mbs_sync #(
        .W     (mbs_pkg::BSR_W)
    ) u_ring_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (ring_in),
        .q     (ring_s)
    );

    assign tck_s = pin_s[2];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[0];

    // reset value matches the idle low test clock, so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_d_r <= 1'h0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    assign rise = tck_s & ~tck_d_r;
    assign fall = ~tck_s & tck_d_r;

    // ========================================
    // tap controller
    mbs_pkg::mbs_state_t state_r;
    mbs_pkg::mbs_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r) // see R10
            mbs_pkg::MBS_RESET:  state_nxt = tms_s ? mbs_pkg::MBS_RESET  : mbs_pkg::MBS_IDLE;
            mbs_pkg::MBS_IDLE:   state_nxt = tms_s ? mbs_pkg::MBS_SEL_DR : mbs_pkg::MBS_IDLE;
            mbs_pkg::MBS_SEL_DR: state_nxt = tms_s ? mbs_pkg::MBS_SEL_IR : mbs_pkg::MBS_CAP_DR;
            mbs_pkg::MBS_CAP_DR: state_nxt = tms_s ? mbs_pkg::MBS_EX1_DR : mbs_pkg::MBS_SH_DR;
            mbs_pkg::MBS_SH_DR:  state_nxt = tms_s ? mbs_pkg::MBS_EX1_DR : mbs_pkg::MBS_SH_DR;
            mbs_pkg::MBS_EX1_DR: state_nxt = tms_s ? mbs_pkg::MBS_UPD_DR : mbs_pkg::MBS_PAU_DR;
            mbs_pkg::MBS_PAU_DR: state_nxt = tms_s ? mbs_pkg::MBS_EX2_DR : mbs_pkg::MBS_PAU_DR;
            mbs_pkg::MBS_EX2_DR: state_nxt = tms_s ? mbs_pkg::MBS_UPD_DR : mbs_pkg::MBS_SH_DR;
            mbs_pkg::MBS_UPD_DR: state_nxt = tms_s ? mbs_pkg::MBS_SEL_DR : mbs_pkg::MBS_IDLE;
            mbs_pkg::MBS_SEL_IR: state_nxt = tms_s ? mbs_pkg::MBS_RESET  : mbs_pkg::MBS_CAP_IR;
            mbs_pkg::MBS_CAP_IR: state_nxt = tms_s ? mbs_pkg::MBS_EX1_IR : mbs_pkg::MBS_SH_IR;
            mbs_pkg::MBS_SH_IR:  state_nxt = tms_s ? mbs_pkg::MBS_EX1_IR : mbs_pkg::MBS_SH_IR;
            mbs_pkg::MBS_EX1_IR: state_nxt = tms_s ? mbs_pkg::MBS_UPD_IR : mbs_pkg::MBS_PAU_IR;
            mbs_pkg::MBS_PAU_IR: state_nxt = tms_s ? mbs_pkg::MBS_EX2_IR : mbs_pkg::MBS_PAU_IR;
            mbs_pkg::MBS_EX2_IR: state_nxt = tms_s ? mbs_pkg::MBS_UPD_IR : mbs_pkg::MBS_SH_IR;
            mbs_pkg::MBS_UPD_IR: state_nxt = tms_s ? mbs_pkg::MBS_SEL_DR : mbs_pkg::MBS_IDLE;
            default:             state_nxt = mbs_pkg::MBS_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= mbs_pkg::MBS_RESET;
        end else if (rise) begin
            state_r <= state_nxt;
        end
    end

    // ========================================
    // instruction register and decode
    logic [mbs_pkg::IR_W-1:0] ir_sh_r;  // see R1
    logic [mbs_pkg::IR_W-1:0] ir_r;
    logic                     sel_bsr;
    logic                     sel_id;
    logic                     sel_byp;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r <= '0;
        end else if (rise && state_r == mbs_pkg::MBS_CAP_IR) begin
            ir_sh_r <= {6'h00, mbs_pkg::IR_CAPTURE}; // see R12
        end else if (rise && state_r == mbs_pkg::MBS_SH_IR) begin
            ir_sh_r <= {tdi_s, ir_sh_r[mbs_pkg::IR_W-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_r <= mbs_pkg::IR_RESET;
        end else if (state_r == mbs_pkg::MBS_RESET) begin
            ir_r <= mbs_pkg::IR_RESET; // see R11
        end else if (rise && state_r == mbs_pkg::MBS_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    always_comb begin
        sel_bsr = 1'h0;
        sel_id  = 1'h0;
        sel_byp = 1'h0;
        if (ir_r == mbs_pkg::OP_EXTEST || ir_r == mbs_pkg::OP_SAMPLE) begin
            sel_bsr = 1'h1; // see R2
        end else if (ir_r == mbs_pkg::OP_IDCODE) begin
            sel_id = 1'h1; // see R3
        end else if (ir_r == mbs_pkg::OP_CLAMP || ir_r == mbs_pkg::OP_HIGHZ) begin
            sel_byp = 1'h1; // see R4 R5
        end else if (ir_r == mbs_pkg::OP_BYPASS) begin
            sel_byp = 1'h1; // see R6
        end else begin
            sel_byp = 1'h1; // see R14
        end
    end

    // ========================================
    // bypass and identification registers
    logic        byp_r;
    logic [31:0] id_sh_r;
    logic [31:0] id_value;

    always_comb begin
        id_value = '0;
        id_value[mbs_pkg::ID_REV_LSB +: 4]  = REV_ID; // see R7
        id_value[mbs_pkg::ID_DEV_LSB +: 16] = DEV_ID;
        id_value[mbs_pkg::ID_MFR_LSB +: 11] = MFR_ID;
        id_value[0]                         = 1'h1;   // see R8
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_r <= 1'h0;
        end else if (rise && sel_byp && state_r == mbs_pkg::MBS_CAP_DR) begin
            byp_r <= 1'h0; // see R13
        end else if (rise && sel_byp && state_r == mbs_pkg::MBS_SH_DR) begin
            byp_r <= tdi_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_sh_r <= '0;
        end else if (rise && sel_id && state_r == mbs_pkg::MBS_CAP_DR) begin
            id_sh_r <= id_value; // see R3
        end else if (rise && sel_id && state_r == mbs_pkg::MBS_SH_DR) begin
            id_sh_r <= {tdi_s, id_sh_r[31:1]};
        end
    end

    // ========================================
    // boundary scan cells: cell 0 is exit bit 1, nearest the serial output
    logic [mbs_pkg::BSR_W-1:0] bsr_sh_r;
    logic [mbs_pkg::BSR_W-1:0] bsr_upd_r;

    genvar gi;
    generate
        for (gi = 0; gi < mbs_pkg::BSR_W; gi = gi + 1) begin : g_cell
            logic shift_src;
            if (gi == mbs_pkg::BSR_W - 1) begin : g_top
                assign shift_src = tdi_s;
            end else begin : g_mid
                assign shift_src = bsr_sh_r[gi+1]; // see R9
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bsr_sh_r[gi]  <= 1'h0;
                    bsr_upd_r[gi] <= 1'h0;
                end else if (rise && sel_bsr) begin
                    if (state_r == mbs_pkg::MBS_CAP_DR) begin
                        bsr_sh_r[gi] <= ring_s[gi]; // see R2
                    end else if (state_r == mbs_pkg::MBS_SH_DR) begin
                        bsr_sh_r[gi] <= shift_src;
                    end else if (state_r == mbs_pkg::MBS_UPD_DR) begin
                        bsr_upd_r[gi] <= bsr_sh_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ========================================
    // serial output, changed on the falling test clock edge
    logic dr_bit;

    always_comb begin
        dr_bit = byp_r;
        if (sel_bsr) begin
            dr_bit = bsr_sh_r[0];
        end else if (sel_id) begin
            dr_bit = id_sh_r[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else if (fall) begin
            if (state_r == mbs_pkg::MBS_SH_IR) begin
                tdo    <= ir_sh_r[0];
                tdo_oe <= 1'h1;
            end else if (state_r == mbs_pkg::MBS_SH_DR) begin
                tdo    <= dr_bit;
                tdo_oe <= 1'h1;
            end else begin
                tdo_oe <= 1'h0; // see R10
            end
        end
    end

    // ========================================
    // io ring control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_drive <= 1'h0;
            force_hiz  <= 1'h0;
        end else begin
            test_drive <= (ir_r == mbs_pkg::OP_EXTEST) || (ir_r == mbs_pkg::OP_CLAMP); // see R4
            force_hiz  <= (ir_r == mbs_pkg::OP_HIGHZ); // see R5
        end
    end

    assign ring_test_out = bsr_upd_r;
    assign active_ir     = ir_r;

    // ========================================
    // assertions
    ir_capture_a: assert property ( // see R12
        @(posedge clk) disable iff (!rst_n)
        (rise && state_r == mbs_pkg::MBS_CAP_IR) |=> (ir_sh_r[1:0] == mbs_pkg::IR_CAPTURE))
        else $error("capture-ir pattern missing");

    ir_reset_a: assert property ( // see R11
        @(posedge clk) disable iff (!rst_n)
        (state_r == mbs_pkg::MBS_RESET) |=> (ir_r == mbs_pkg::OP_IDCODE))
        else $error("idcode not active in test-logic-reset");

    id_capture_a: assert property ( // see R7 R8
        @(posedge clk) disable iff (!rst_n)
        (rise && sel_id && state_r == mbs_pkg::MBS_CAP_DR) |=>
            (id_sh_r[0] && id_sh_r[31:28] == REV_ID && id_sh_r[11:1] == MFR_ID))
        else $error("id capture wrong");

    bypass_clear_a: assert property ( // see R13
        @(posedge clk) disable iff (!rst_n)
        (rise && sel_byp && state_r == mbs_pkg::MBS_CAP_DR) |=> !byp_r)
        else $error("bypass not cleared on capture");

    bsr_shift_a: assert property ( // see R9
        @(posedge clk) disable iff (!rst_n)
        (rise && sel_bsr && state_r == mbs_pkg::MBS_SH_DR) |=>
            (bsr_sh_r[mbs_pkg::BSR_W-2:0] == $past(bsr_sh_r[mbs_pkg::BSR_W-1:1])))
        else $error("boundary chain shift order wrong");

    hiz_force_a: assert property ( // see R5
        @(posedge clk) disable iff (!rst_n)
        (ir_r == mbs_pkg::OP_HIGHZ) |=> (force_hiz && !test_drive))
        else $error("high-z not forced");

    clamp_drive_a: assert property ( // see R4
        @(posedge clk) disable iff (!rst_n)
        (ir_r == mbs_pkg::OP_CLAMP) |=> (test_drive && !force_hiz))
        else $error("clamp does not drive ring");

    shift_oe_a: assert property ( // see R10
        @(posedge clk) disable iff (!rst_n)
        (fall && (state_r == mbs_pkg::MBS_SH_DR || state_r == mbs_pkg::MBS_SH_IR)) |=> tdo_oe)
        else $error("serial output not enabled while shifting");
endmodule
